/* rtl/lucsr_pkg.sv */
// Constants for the per-port line unit control and status register bank
package lucsr_pkg;

    // Register indices (byte address is four times the index)
    localparam logic [13:0] LUCSR_IDX_TX_RX_CTRL  = 14'h1000;
    localparam logic [13:0] LUCSR_IDX_TX_SHAPE    = 14'h1001;
    localparam logic [13:0] LUCSR_IDX_MAINT_CTRL  = 14'h1002;
    localparam logic [13:0] LUCSR_IDX_LIVE_STATUS = 14'h1003;
    localparam logic [13:0] LUCSR_IDX_IRQ_MASK    = 14'h1004;
    localparam logic [13:0] LUCSR_IDX_LATCHED     = 14'h1005;
    localparam logic [13:0] LUCSR_PORT_STRIDE     = 14'h0020;
    localparam logic [13:0] LUCSR_GROUP_STRIDE    = 14'h2000;
    localparam int          LUCSR_PORTS_PER_GROUP = 8;
    localparam int          LUCSR_MAX_PORTS       = 16;

    // Register slots within one port window
    localparam logic [4:0]  LUCSR_SLOT_TX_RX_CTRL  = 5'h00;
    localparam logic [4:0]  LUCSR_SLOT_TX_SHAPE    = 5'h01;
    localparam logic [4:0]  LUCSR_SLOT_MAINT_CTRL  = 5'h02;
    localparam logic [4:0]  LUCSR_SLOT_LIVE_STATUS = 5'h03;
    localparam logic [4:0]  LUCSR_SLOT_IRQ_MASK    = 5'h04;
    localparam logic [4:0]  LUCSR_SLOT_LATCHED     = 5'h05;

    // Writable bit masks
    localparam logic [7:0]  LUCSR_CTRL_WMASK   = 8'h3f;
    localparam logic [7:0]  LUCSR_SHAPE_WMASK  = 8'hf7;
    localparam logic [7:0]  LUCSR_MAINT_WMASK  = 8'hff;
    localparam logic [7:0]  LUCSR_MASK_WMASK   = 8'hff;
    localparam logic [7:0]  LUCSR_RESET_VALUE  = 8'h00;

    // Transmit/receive control fields
    localparam int LUCSR_LSC_BIT      = 0;
    localparam int LUCSR_STD_BIT      = 1;
    localparam int LUCSR_JITTER_STAGE_PLACEMENT_LSB     = 2;
    localparam int LUCSR_JITTER_BUFFER_DEPTH_LSB     = 4;
    // Transmit shape fields
    localparam int LUCSR_SHAPE_LSB    = 0;
    localparam int LUCSR_TX_LOAD_IMPEDANCE_LSB    = 4;
    localparam int LUCSR_TERM_BIT     = 6;
    localparam int LUCSR_SYNC_BIT     = 7;
    // Maintenance fields
    localparam int LUCSR_TE_BIT       = 0;
    localparam int LUCSR_RPD_BIT      = 1;
    localparam int LUCSR_TPD_BIT      = 2;
    localparam int LUCSR_LB_LSB       = 3;
    localparam int LUCSR_AUTO_AIS_BIT = 6;
    localparam int LUCSR_MAN_AIS_BIT  = 7;

    // Jitter buffer depths in bits
    localparam logic [7:0] LUCSR_DEPTH_128 = 8'h80;
    localparam logic [7:0] LUCSR_DEPTH_64  = 8'h40;
    localparam logic [7:0] LUCSR_DEPTH_32  = 8'h20;
    localparam logic [7:0] LUCSR_DEPTH_16  = 8'h10;

    // Loss-of-signal criteria codes
    localparam logic [1:0] LUCSR_LOS_G775   = 2'h0;
    localparam logic [1:0] LUCSR_LOS_ETS    = 2'h1;
    localparam logic [1:0] LUCSR_LOS_T1231  = 2'h2;

    // Transmit source codes
    localparam logic [1:0] LUCSR_TXSRC_DATA  = 2'h0;
    localparam logic [1:0] LUCSR_TXSRC_ALARM = 2'h1;
    localparam logic [1:0] LUCSR_TXSRC_SYNC  = 2'h2;

    // Loopback codes
    localparam logic [2:0] LUCSR_LB_NONE     = 3'h0;
    localparam logic [2:0] LUCSR_LB_DUAL     = 3'h5;

endpackage : lucsr_pkg

/* rtl/lucsr_regs.sv */
// APB register bank for the per-port line unit control and status registers
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Depth field codes 00..11 give buffer depth 128, 64, 32, 16 bits.
// - Placement field: 00 receive path, 01 transmit path, 10/11 disabled.
// - Line standard bit: 0 selects E1, 1 selects T1 or J1.
// - Loss criteria bit picks G.775 or ETS in E1; T1.231 always in T1/J1.
// - Sync clock bit sends 2.048MHz clock instead of data.
// - Termination bit switches internal transmit termination on or off.
// - Three-bit pulse shape field selects the transmit waveshape per line standard.
// - Manual alarm bit sends unframed all-ones, ignoring framer data.
// - Automatic alarm bit sends all-ones while loss of signal is seen.
// - Loopback field selects none, remote, analog, local or dual; 110/111 reserved.
// - Transmit power-down bit powers transmitter off and floats line outputs.
// - Receiver power-down bit powers receiver off.
// - Output enable bit drives line outputs; external enable pin overrides it.
// - Live status shows over-equalized bit 5 and under-equalized bit 4.
// - Live status shows receive short bit 3 and transmit short bit 2.
// - Live status bit 1 shows transmit open circuit while present.
// - Live status bit 0 shows receive loss of signal while present.
// - Port copies sit at base plus 20h per port plus 2000h per eight ports.
// - Mask bit 1 lets its latched event interrupt; 0 blocks it.
// - Latched bits set on detection and removal, hold until cleared.
module lucsr_regs #(
    parameter int N_PORTS = 16
) (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          reset_n,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [15:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic                               pready,
    output logic [31:0]                        prdata,
    output logic                               pslverr,
    // Live conditions from the analog front end, per port
    input  wire logic [N_PORTS-1:0]            equalizer_over,
    input  wire logic [N_PORTS-1:0]            equalizer_under,
    input  wire logic [N_PORTS-1:0]            rx_short_live,
    input  wire logic [N_PORTS-1:0]            tx_short_live,
    input  wire logic [N_PORTS-1:0]            tx_open_live,
    input  wire logic [N_PORTS-1:0]            signal_loss_live,
    input  wire logic [N_PORTS-1:0]            jitter_limit_live,
    // External transmit enable pin
    input  wire logic                          tx_enable_pin,
    // Jitter attenuator steering
    output logic [N_PORTS-1:0][7:0]            jitter_buffer_depth,
    output logic [N_PORTS-1:0]                 jitter_in_rx_path,
    output logic [N_PORTS-1:0]                 jitter_in_tx_path,
    // Line standard and receive controls
    output logic [N_PORTS-1:0]                 line_standard_select,
    output logic [N_PORTS-1:0][1:0]            signal_loss_criteria,
    output logic [N_PORTS-1:0]                 rx_power_down,
    // Transmit controls
    output logic [N_PORTS-1:0]                 tx_termination_on,
    output logic [N_PORTS-1:0][1:0]            tx_load_impedance,
    output logic [N_PORTS-1:0][2:0]            tx_pulse_shape,
    output logic [N_PORTS-1:0][1:0]            tx_source,
    output logic [N_PORTS-1:0]                 tx_power_down,
    output logic [N_PORTS-1:0]                 tx_line_oe,
    output logic [N_PORTS-1:0][2:0]            loopback_select,
    // Masked latched events, per port
    output logic [N_PORTS-1:0]                 port_irq
);
    import lucsr_pkg::*;

    // Port select is four bits wide, so sixteen ports at most
    if (N_PORTS < 1 || N_PORTS > LUCSR_MAX_PORTS) begin : g_bad_ports
        $error("N_PORTS must be 1 to 16");
    end

    typedef struct packed {
        logic [N_PORTS-1:0][7:0] ctrl;
        logic [N_PORTS-1:0][7:0] shape;
        logic [N_PORTS-1:0][7:0] maint;
        logic [N_PORTS-1:0][7:0] mask;
        logic [N_PORTS-1:0][7:0] latched;
        logic [N_PORTS-1:0][3:0] cond_prev;
        logic [31:0]             rdata;
    } lucsr_state_t;

    lucsr_state_t state_r;
    lucsr_state_t state_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    logic [13:0] idx;
    logic [4:0]  slot;
    logic [3:0]  port_sel;
    logic        hit;
    logic        wr_en;
    logic        rd_setup;

    // Upper group adds 2000h and 8*20h, so bit 8 always equals bit 13
    always_comb begin
        idx      = paddr[15:2];
        slot     = idx[4:0];
        port_sel = {idx[13], idx[7:5]};
        hit      = (paddr[1:0] == 2'h0)
                && (idx[12:9] == LUCSR_IDX_TX_RX_CTRL[12:9])
                && (idx[8] == idx[13])
                && (slot <= LUCSR_SLOT_LATCHED)
                && (32'(port_sel) < 32'(N_PORTS));
        wr_en    = psel && penable && pwrite && hit && pstrb[0];
        rd_setup = psel && !penable && !pwrite;
    end

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = state_r.rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Live status and next state

    logic [N_PORTS-1:0][7:0] live;
    logic [N_PORTS-1:0][3:0] cond;

    always_comb begin
        state_nxt = state_r;
        for (int p = 0; p < N_PORTS; p++) begin
            live[p] = {2'h0, equalizer_over[p], equalizer_under[p],
                       rx_short_live[p], tx_short_live[p],
                       tx_open_live[p], signal_loss_live[p]};
            cond[p] = {jitter_limit_live[p], tx_open_live[p],
                       tx_short_live[p], signal_loss_live[p]};
            state_nxt.cond_prev[p] = cond[p];

            if (wr_en && port_sel == p[3:0]) begin
                unique case (slot)
                    LUCSR_SLOT_TX_RX_CTRL:
                        state_nxt.ctrl[p] = pwdata[7:0] & LUCSR_CTRL_WMASK;
                    LUCSR_SLOT_TX_SHAPE:
                        state_nxt.shape[p] = pwdata[7:0] & LUCSR_SHAPE_WMASK;
                    LUCSR_SLOT_MAINT_CTRL:
                        state_nxt.maint[p] = pwdata[7:0] & LUCSR_MAINT_WMASK;
                    LUCSR_SLOT_IRQ_MASK:
                        state_nxt.mask[p] = pwdata[7:0] & LUCSR_MASK_WMASK;
                    LUCSR_SLOT_LATCHED:
                        state_nxt.latched[p] = state_r.latched[p] & ~pwdata[7:0];
                    default: ;
                endcase
            end

            // Rising edge sets low nibble, falling edge high nibble; set beats clear
            state_nxt.latched[p] = state_nxt.latched[p]
                                 | {~cond[p] & state_r.cond_prev[p],
                                     cond[p] & ~state_r.cond_prev[p]};
        end

        // Read data captured in setup so access phase sees a flop
        if (rd_setup) begin
            state_nxt.rdata = 32'h0000_0000;
            if (hit) begin
                unique case (slot)
                    LUCSR_SLOT_TX_RX_CTRL:
                        state_nxt.rdata[7:0] = state_r.ctrl[port_sel];
                    LUCSR_SLOT_TX_SHAPE:
                        state_nxt.rdata[7:0] = state_r.shape[port_sel];
                    LUCSR_SLOT_MAINT_CTRL:
                        state_nxt.rdata[7:0] = state_r.maint[port_sel];
                    LUCSR_SLOT_LIVE_STATUS:
                        state_nxt.rdata[7:0] = live[port_sel];
                    LUCSR_SLOT_IRQ_MASK:
                        state_nxt.rdata[7:0] = state_r.mask[port_sel];
                    LUCSR_SLOT_LATCHED:
                        state_nxt.rdata[7:0] = state_r.latched[port_sel];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-port decode of control fields

    for (genvar g = 0; g < N_PORTS; g++) begin : g_port
        logic [1:0] depth_code;
        logic [1:0] place_code;
        logic       alarm;

        assign depth_code = state_r.ctrl[g][LUCSR_JITTER_BUFFER_DEPTH_LSB +: 2];
        assign place_code = state_r.ctrl[g][LUCSR_JITTER_STAGE_PLACEMENT_LSB +: 2];

        always_comb begin
            unique case (depth_code)
                2'h0: jitter_buffer_depth[g] = LUCSR_DEPTH_128;
                2'h1: jitter_buffer_depth[g] = LUCSR_DEPTH_64;
                2'h2: jitter_buffer_depth[g] = LUCSR_DEPTH_32;
                2'h3: jitter_buffer_depth[g] = LUCSR_DEPTH_16;
            endcase
        end

        assign jitter_in_rx_path[g] = (place_code == 2'h0);
        assign jitter_in_tx_path[g] = (place_code == 2'h1);

        assign line_standard_select[g] = state_r.ctrl[g][LUCSR_STD_BIT];

        // T1/J1 ignores the criteria bit
        assign signal_loss_criteria[g] = state_r.ctrl[g][LUCSR_STD_BIT] ? LUCSR_LOS_T1231
                                       : state_r.ctrl[g][LUCSR_LSC_BIT] ? LUCSR_LOS_ETS
                                       : LUCSR_LOS_G775;

        assign tx_termination_on[g] = state_r.shape[g][LUCSR_TERM_BIT];
        assign tx_load_impedance[g] = state_r.shape[g][LUCSR_TX_LOAD_IMPEDANCE_LSB +: 2];
        // Meaning of the shape code follows the line standard bit downstream
        assign tx_pulse_shape[g]    = state_r.shape[g][LUCSR_SHAPE_LSB +: 3];

        assign alarm = state_r.maint[g][LUCSR_MAN_AIS_BIT]
                     | (state_r.maint[g][LUCSR_AUTO_AIS_BIT] & signal_loss_live[g]);

        // Alarm wins over sync clock: all-ones must reach the far end
        assign tx_source[g] = alarm ? LUCSR_TXSRC_ALARM
                            : state_r.shape[g][LUCSR_SYNC_BIT] ? LUCSR_TXSRC_SYNC
                            : LUCSR_TXSRC_DATA;

        // Reserved loopback codes fall back to none
        assign loopback_select[g] = (state_r.maint[g][LUCSR_LB_LSB +: 3] > LUCSR_LB_DUAL)
                                  ? LUCSR_LB_NONE
                                  : state_r.maint[g][LUCSR_LB_LSB +: 3];

        assign tx_power_down[g] = state_r.maint[g][LUCSR_TPD_BIT];
        assign rx_power_down[g] = state_r.maint[g][LUCSR_RPD_BIT];

        // Pin low forces high impedance whatever the bit says
        assign tx_line_oe[g] = state_r.maint[g][LUCSR_TE_BIT] && tx_enable_pin
                            && !state_r.maint[g][LUCSR_TPD_BIT];

        assign port_irq[g] = |(state_r.latched[g] & state_r.mask[g]);
    end

endmodule : lucsr_regs

`default_nettype wire

/* tb/lucsr_regs_monitor.sv */
// Assertion checker for the line unit register bank, port 1 and address decode
`timescale 1ns/1ps
`default_nettype none
module lucsr_regs_monitor
    import lucsr_pkg::*;
#(
    parameter int N_PORTS = 16
) (
    // Clock, reset and APB
    input wire logic                     clock,
    input wire logic                     reset_n,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [15:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [3:0]               pstrb,
    input wire logic                     pslverr,
    input wire logic [31:0]              prdata,
    // Line side
    input wire logic [N_PORTS-1:0]       signal_loss_live,
    input wire logic                     tx_enable_pin,
    input wire logic [N_PORTS-1:0]       tx_line_oe,
    input wire logic [N_PORTS-1:0][1:0]  tx_source,
    input wire logic [N_PORTS-1:0][7:0]  jitter_buffer_depth,
    input wire logic [N_PORTS-1:0]       jitter_in_rx_path,
    input wire logic [N_PORTS-1:0][2:0]  loopback_select,
    input wire logic [N_PORTS-1:0]       port_irq
);
    logic apb_wr;
    assign apb_wr = psel && penable && pwrite && pstrb[0];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////
    a_depth_decode: assert property (apb_wr && paddr == 16'h4000 |=>
        jitter_buffer_depth[0] == (8'h80 >> $past(pwdata[5:4]))) else $error("depth decode");
    a_place_decode: assert property (apb_wr && paddr == 16'h4000 |=>
        jitter_in_rx_path[0] == ($past(pwdata[3:2]) == 2'h0)) else $error("placement decode");
    a_oe_pin_gate: assert property (!tx_enable_pin |-> tx_line_oe == '0)
        else $error("outputs driven with pin low");
    a_manual_alarm: assert property (apb_wr && paddr == 16'h4008 && pwdata[7] |=>
        tx_source[0] == LUCSR_TXSRC_ALARM) else $error("alarm not sent");
    a_loop_reserved: assert property (apb_wr && paddr == 16'h4008 |=>
        loopback_select[0] == (($past(pwdata[5:4]) == 2'h3) ? 3'h0 : $past(pwdata[5:3])))
        else $error("loopback decode");
    a_bad_addr_err: assert property (psel && penable &&
        (paddr[1:0] != 2'h0 || paddr[15:2] == 14'h1006) |-> pslverr) else $error("no error");
    a_irq_masked: assert property (apb_wr && paddr == 16'h4010 && pwdata[7:0] == 8'h00
        |=> !port_irq[0]) else $error("masked interrupt seen");
    a_live_read: assert property (psel && !penable && !pwrite && paddr == 16'h400c |=>
        prdata[0] == $past(signal_loss_live[0])) else $error("live status read");
    a_reset_quiet: assert property ($rose(reset_n) |->
        tx_line_oe == '0 && loopback_select[0] == 3'h0) else $error("not quiet after reset");
    c_ctrl_write: cover property (apb_wr && paddr == 16'h4000);
    c_bad_access: cover property (pslverr);
    c_irq_seen: cover property (port_irq[0]);
endmodule : lucsr_regs_monitor
`default_nettype wire

/* tb/lucsr_front_end.sv */
// Behavioural line front end raising live conditions on one port
`timescale 1ns/1ps
`default_nettype none
module lucsr_front_end #(
    parameter int N_PORTS = 16
) (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                reset_n,
    // Condition request, bit order as in the live status register
    input  wire logic [3:0]          port_sel,
    input  wire logic [6:0]          cond,
    // Live levels
    output logic [N_PORTS-1:0]       signal_loss_live,
    output logic [N_PORTS-1:0]       tx_open_live,
    output logic [N_PORTS-1:0]       tx_short_live,
    output logic [N_PORTS-1:0]       rx_short_live,
    output logic [N_PORTS-1:0]       equalizer_under,
    output logic [N_PORTS-1:0]       equalizer_over,
    output logic [N_PORTS-1:0]       jitter_limit_live
);
    logic [6:0][N_PORTS-1:0] lv_r;
    // Synchronous levels, other ports quiet
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lv_r <= '0;
        end else begin
            for (int b = 0; b < 7; b++) begin
                lv_r[b]           <= '0;
                lv_r[b][port_sel] <= cond[b];
            end
        end
    end
    assign signal_loss_live  = lv_r[0];
    assign tx_open_live      = lv_r[1];
    assign tx_short_live     = lv_r[2];
    assign rx_short_live     = lv_r[3];
    assign equalizer_under   = lv_r[4];
    assign equalizer_over    = lv_r[5];
    assign jitter_limit_live = lv_r[6];
endmodule : lucsr_front_end
`default_nettype wire

/* tb/lucsr_regs_tb.sv */
// Self-checking testbench for the line unit register bank
`timescale 1ns/1ps
`default_nettype none
module lucsr_regs_tb;
    import lucsr_pkg::*;
    localparam int NP = 9;
    logic               clock = 1'b0, reset_n = 1'b0, tx_enable_pin = 1'b0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err_q;
    logic [15:0]        paddr = 16'h0;
    logic [31:0]        pwdata = 32'h0, prdata, rd_q;
    logic [3:0]         pstrb = 4'hf, port_sel = 4'h0;
    logic [6:0]         cond = 7'h0;
    logic [NP-1:0]      eq_o, eq_u, rx_sh, tx_sh, tx_op, loss, jit, rx_in, tx_in, std, rx_pd;
    logic [NP-1:0]      term, tx_pd, oe, irq;
    logic [NP-1:0][7:0] depth;
    logic [NP-1:0][1:0] crit, load, src;
    logic [NP-1:0][2:0] shape, loopb;
    int                 checks = 0, mismatches = 0, cyc = 0;
    always #5 clock = ~clock;
    lucsr_regs #(.N_PORTS(NP)) lucsr_regs_inst (.clock(clock), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .equalizer_over(eq_o),
        .equalizer_under(eq_u), .rx_short_live(rx_sh), .tx_short_live(tx_sh),
        .tx_open_live(tx_op), .signal_loss_live(loss), .jitter_limit_live(jit),
        .tx_enable_pin(tx_enable_pin), .jitter_buffer_depth(depth), .jitter_in_rx_path(rx_in),
        .jitter_in_tx_path(tx_in), .line_standard_select(std), .signal_loss_criteria(crit),
        .rx_power_down(rx_pd), .tx_termination_on(term), .tx_load_impedance(load),
        .tx_pulse_shape(shape), .tx_source(src), .tx_power_down(tx_pd), .tx_line_oe(oe),
        .loopback_select(loopb), .port_irq(irq));
    lucsr_front_end #(.N_PORTS(NP)) lucsr_front_end_inst (.clock(clock), .reset_n(reset_n),
        .port_sel(port_sel), .cond(cond), .signal_loss_live(loss), .tx_open_live(tx_op),
        .tx_short_live(tx_sh), .rx_short_live(rx_sh), .equalizer_under(eq_u),
        .equalizer_over(eq_o), .jitter_limit_live(jit));
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Entered just after an edge; one idle edge after release avoids double drives
    task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        // Only the bench timeout ends a stalled access
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
        apb(1'b0, a, 8'h00);
        chk(nm, rd_q, {24'h0, exp});
    endtask : rd
    function automatic logic [15:0] ad(input int p, input logic [4:0] s);
        logic [13:0] idx;
        idx = LUCSR_IDX_TX_RX_CTRL + 14'(s) + LUCSR_PORT_STRIDE * 14'(p - 1)
            + LUCSR_GROUP_STRIDE * 14'((p - 1) / 8);
        return {idx, 2'b00};
    endfunction : ad
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        for (int s = 0; s < 6; s++) rd(ad(1, 5'(s)), 8'h00, "reset");
        chk("oe reset", 32'(oe), 32'h0);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, ad(1, LUCSR_SLOT_TX_RX_CTRL), {2'b11, 4'(i), 2'(i)});
            chk("depth", 32'(depth[0]), 32'h80 >> i[3:2]);
            chk("rx path", 32'(rx_in[0]), 32'(i[1:0] == 2'h0));
            chk("tx path", 32'(tx_in[0]), 32'(i[1:0] == 2'h1));
            chk("standard", 32'(std[0]), 32'(i[1]));
            chk("criteria", 32'(crit[0]), i[1] ? 32'h2 : 32'(i[0]));
            rd(ad(1, LUCSR_SLOT_TX_RX_CTRL), {2'b00, 4'(i), 2'(i)}, "ctrl");
        end
        apb(1'b1, ad(9, LUCSR_SLOT_TX_RX_CTRL), 8'h20);
        chk("port9 depth", 32'(depth[8]), 32'h20);
        chk("port1 depth", 32'(depth[0]), 32'h10);
        rd(ad(10, LUCSR_SLOT_TX_RX_CTRL), 8'h00, "port10");
        chk("port10 err", 32'(err_q), 32'h1);
        rd(ad(1, 5'h6), 8'h00, "slot6");
        chk("slot6 err", 32'(err_q), 32'h1);
        apb(1'b1, ad(1, LUCSR_SLOT_TX_SHAPE), 8'hff);
        rd(ad(1, LUCSR_SLOT_TX_SHAPE), 8'hf7, "shape");
        chk("term", 32'(term[0]), 32'h1);
        chk("load", 32'(load[0]), 32'h3);
        chk("pulse", 32'(shape[0]), 32'h7);
        chk("sync", 32'(src[0]), 32'(LUCSR_TXSRC_SYNC));
        for (int lb = 0; lb < 8; lb++) begin
            apb(1'b1, ad(1, LUCSR_SLOT_MAINT_CTRL), 8'(lb << 3) | 8'h80);
            chk("loop", 32'(loopb[0]), lb > 5 ? 32'h0 : 32'(lb));
            chk("alarm", 32'(src[0]), 32'(LUCSR_TXSRC_ALARM));
        end
        tx_enable_pin <= 1'b1;
        apb(1'b1, ad(1, LUCSR_SLOT_MAINT_CTRL), 8'h03);
        chk("oe on", 32'(oe[0]), 32'h1);
        chk("rx pd", 32'(rx_pd[0]), 32'h1);
        tx_enable_pin <= 1'b0;
        @(posedge clock);
        chk("oe pin", 32'(oe[0]), 32'h0);
        tx_enable_pin <= 1'b1;
        apb(1'b1, ad(1, LUCSR_SLOT_MAINT_CTRL), 8'h05);
        chk("oe pd", 32'(oe[0]), 32'h0);
        chk("tx pd", 32'(tx_pd[0]), 32'h1);
        apb(1'b1, ad(1, LUCSR_SLOT_TX_SHAPE), 8'h00);
        apb(1'b1, ad(1, LUCSR_SLOT_MAINT_CTRL), 8'h40);
        chk("no loss", 32'(src[0]), 32'(LUCSR_TXSRC_DATA));
        cond <= 7'h01;
        repeat (2) @(posedge clock);
        chk("auto", 32'(src[0]), 32'(LUCSR_TXSRC_ALARM));
        apb(1'b1, ad(1, LUCSR_SLOT_LIVE_STATUS), 8'hff);
        rd(ad(1, LUCSR_SLOT_LIVE_STATUS), 8'h01, "live");
        rd(ad(1, LUCSR_SLOT_LATCHED), 8'h01, "latched");
        chk("irq masked", 32'(irq[0]), 32'h0);
        apb(1'b1, ad(1, LUCSR_SLOT_IRQ_MASK), 8'h11);
        chk("irq", 32'(irq[0]), 32'h1);
        pstrb <= 4'h0;
        apb(1'b1, ad(1, LUCSR_SLOT_IRQ_MASK), 8'h00);
        pstrb <= 4'hf;
        rd(ad(1, LUCSR_SLOT_IRQ_MASK), 8'h11, "strobe off");
        apb(1'b1, ad(1, LUCSR_SLOT_MAINT_CTRL), 8'h00);
        chk("auto off", 32'(src[0]), 32'(LUCSR_TXSRC_DATA));
        for (int b = 1; b < 6; b++) begin
            cond <= 7'(1 << b);
            @(posedge clock);
            rd(ad(1, LUCSR_SLOT_LIVE_STATUS), 8'(1 << b), "live");
        end
        rd(ad(1, LUCSR_SLOT_LATCHED), 8'h77, "latched fall");
        cond <= 7'h40;
        repeat (2) @(posedge clock);
        cond <= 7'h00;
        repeat (2) @(posedge clock);
        rd(ad(1, LUCSR_SLOT_LATCHED), 8'hff, "latched jitter");
        apb(1'b1, ad(1, LUCSR_SLOT_LATCHED), 8'hff);
        chk("irq clear", 32'(irq[0]), 32'h0);
        apb(1'b1, ad(1, LUCSR_SLOT_IRQ_MASK), 8'h00);
        end_sim();
    end
endmodule : lucsr_regs_tb
bind lucsr_regs lucsr_regs_monitor #(.N_PORTS(N_PORTS)) lucsr_regs_monitor_inst (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr), .prdata(prdata),
    .signal_loss_live(signal_loss_live), .tx_enable_pin(tx_enable_pin), .tx_line_oe(tx_line_oe),
    .tx_source(tx_source), .jitter_buffer_depth(jitter_buffer_depth),
    .jitter_in_rx_path(jitter_in_rx_path), .loopback_select(loopback_select), .port_irq(port_irq));
`default_nettype wire
